// ===== sim/pms_src_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// selected input source and its frequency meter
module pms_src_model (
  input wire logic clk, // system clock
  input wire logic present, // source switched on
  input wire logic [23:0] freq_set, // source frequency
  output logic valid, // qualified input
  output logic [23:0] freq // measured frequency
);
  always @(posedge clk) begin
    valid <= present;
    if (present) begin
      freq <= freq_set;
    end else begin
      // no source means no measurement; an inverted word keeps a stale value from passing
      freq <= ~freq_set;
    end
  end
endmodule
`default_nettype wire

// ===== sim/pms_top_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "pms_regs.vh"
// ==========================================================
// mode sequencing checks
module pms_top_properties #(
  parameter FW = 24
) (
  input wire logic CLOCK, // clock
  input wire logic RST_N, // reset, active low
  input wire logic INIT_DONE, // init finished
  input wire logic INPUT_VALID, // input usable
  input wire logic [FW-1:0] MEAS_FREQ, // measured frequency
  input wire logic ACQ_DONE, // acquisition complete
  input wire logic FASTLOCK_EN, // fastlock on
  input wire logic RAMP_EXIT_BYPASS, // exit without ramp
  input wire logic [5:0] RAMP_RATE_SEL, // ramp rate
  input wire logic [2:0] HISTORY_WINDOW_LENGTH, // window log2
  input wire logic [4:0] HISTORY_WINDOW_DELAY, // window delay
  input wire logic FALLBACK_FREEZE, // fallback choice
  input wire logic [2:0] MODE, // mode
  input wire logic LOCK_LOST, // not locked
  input wire logic HISTORY_READY_FLAG, // history valid
  input wire logic [1:0] BW_SEL, // bandwidth
  input wire logic [1:0] FREQ_SRC, // loop source
  input wire logic [FW-1:0] FREQ_CMD // measured or held frequency
);
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);
  wire in_loop = (MODE == `PMS_MODE_ACQ) || (MODE == `PMS_MODE_LOCK);

  init_free_a: assert property (MODE == `PMS_MODE_INIT && INIT_DONE |=>
    MODE == `PMS_MODE_FREE && FREQ_SRC == `PMS_SRC_REF) else $error("no free run after init");
  start_acq_a: assert property (MODE == `PMS_MODE_FREE && INPUT_VALID |=> MODE == `PMS_MODE_ACQ &&
    BW_SEL == (FASTLOCK_EN ? `PMS_BW_FAST : `PMS_BW_NORMAL)) else $error("bad acquisition start");
  lock_entry_a: assert property (MODE == `PMS_MODE_ACQ && ACQ_DONE && INPUT_VALID |=>
    MODE == `PMS_MODE_LOCK && BW_SEL == `PMS_BW_NORMAL) else $error("bad lock entry");
  lost_flag_a: assert property (LOCK_LOST == (MODE != `PMS_MODE_LOCK)) else $error("lock lost wrong");
  hold_entry_a: assert property (in_loop && !INPUT_VALID && HISTORY_READY_FLAG |=>
    MODE == `PMS_MODE_HOLD && FREQ_SRC == `PMS_SRC_HELD) else $error("no holdover entry");
  no_history_a: assert property (in_loop && !INPUT_VALID && !HISTORY_READY_FLAG |=>
    MODE == (FALLBACK_FREEZE ? `PMS_MODE_FREEZE : `PMS_MODE_FREE)) else $error("bad fallback");
  freeze_still_a: assert property (MODE == `PMS_MODE_FREEZE && $past(MODE) == `PMS_MODE_FREEZE
    |-> $stable(FREQ_CMD)) else $error("frozen value moved");
  freeze_exit_a: assert property (MODE == `PMS_MODE_FREEZE && INPUT_VALID |=>
    MODE == `PMS_MODE_ACQ) else $error("freeze not left");
  ready_kept_a: assert property (HISTORY_READY_FLAG |=> HISTORY_READY_FLAG) else $error("ready dropped");
  ramp_start_a: assert property (MODE == `PMS_MODE_HOLD && INPUT_VALID && !RAMP_EXIT_BYPASS |=>
    MODE == `PMS_MODE_EXIT) else $error("no ramped exit");
  bypass_exit_a: assert property (MODE == `PMS_MODE_HOLD && INPUT_VALID && RAMP_EXIT_BYPASS |=>
    MODE == `PMS_MODE_ACQ && BW_SEL == `PMS_BW_HOLD_EXIT) else $error("bad bypass exit");
endmodule

bind pms_top pms_top_properties #(.FW(FW)) pms_top_properties_i (
  .CLOCK(CLOCK), .RST_N(RST_N), .INIT_DONE(INIT_DONE), .INPUT_VALID(INPUT_VALID),
  .MEAS_FREQ(MEAS_FREQ), .ACQ_DONE(ACQ_DONE), .FASTLOCK_EN(FASTLOCK_EN),
  .RAMP_EXIT_BYPASS(RAMP_EXIT_BYPASS), .RAMP_RATE_SEL(RAMP_RATE_SEL),
  .HISTORY_WINDOW_LENGTH(HISTORY_WINDOW_LENGTH), .HISTORY_WINDOW_DELAY(HISTORY_WINDOW_DELAY),
  .FALLBACK_FREEZE(FALLBACK_FREEZE), .MODE(MODE), .LOCK_LOST(LOCK_LOST),
  .HISTORY_READY_FLAG(HISTORY_READY_FLAG), .BW_SEL(BW_SEL), .FREQ_SRC(FREQ_SRC), .FREQ_CMD(FREQ_CMD));
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "pms_regs.vh"
module tb;
  logic clk, rst_n, init_done, acq_done, fastlock_en, bypass, freeze_fb, present;
  logic input_valid, lock_lost, ready;
  logic [23:0] freq_set, meas_freq, freq_cmd, last;
  logic [5:0] rate_sel;
  logic [2:0] mode;
  logic [1:0] bw_sel, freq_src;
  int miscompares, n_tests, cnt;

  pms_src_model pms_src_model_i (.clk(clk), .present(present), .freq_set(freq_set),
    .valid(input_valid), .freq(meas_freq));
  pms_top #(.FW(24), .TICK_CYCLES(4), .SAMPLE_CYCLES(8)) pms_top_i (
    .CLOCK(clk), .RST_N(rst_n), .INIT_DONE(init_done), .INPUT_VALID(input_valid),
    .MEAS_FREQ(meas_freq), .ACQ_DONE(acq_done), .FASTLOCK_EN(fastlock_en),
    .RAMP_EXIT_BYPASS(bypass), .RAMP_RATE_SEL(rate_sel), .HISTORY_WINDOW_LENGTH(3'h1),
    .HISTORY_WINDOW_DELAY(5'h01), .FALLBACK_FREEZE(freeze_fb), .MODE(mode), .LOCK_LOST(lock_lost),
    .HISTORY_READY_FLAG(ready), .BW_SEL(bw_sel), .FREQ_SRC(freq_src), .FREQ_CMD(freq_cmd));

  // ==========================================================
  // helpers
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chm(input logic [2:0] m);
    chk({21'h0, mode}, {21'h0, m});
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic close_out;
    if (miscompares == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // init_done stays low until the synchronised reset has lifted
  task automatic do_reset(input logic fb);
    rst_n = 1'b0;
    init_done = 1'b0;
    present = 1'b0;
    acq_done = 1'b0;
    freeze_fb = fb;
    step(5);
    chm(`PMS_MODE_INIT);
    chk({23'h0, lock_lost}, 24'h1);
    rst_n = 1'b1;
    step(3);
    init_done = 1'b1;
    step(1);
    chm(`PMS_MODE_FREE);
    chk({22'h0, freq_src}, {22'h0, `PMS_SRC_REF});
  endtask
  task automatic lock_up(input logic [23:0] f);
    freq_set = f;
    present = 1'b1;
    step(2);
    chm(`PMS_MODE_ACQ);
    chk({22'h0, bw_sel}, fastlock_en ? 24'h1 : 24'h0);
    acq_done = 1'b1;
    step(1);
    acq_done = 1'b0;
    chm(`PMS_MODE_LOCK);
    chk({23'h0, lock_lost}, 24'h0);
    chk({22'h0, bw_sel}, {22'h0, `PMS_BW_NORMAL});
    chk(freq_cmd, f);
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    close_out();
  end

  // ==========================================================
  // tests
  initial begin
    miscompares = 0;
    n_tests = 0;
    fastlock_en = 1'b1;
    bypass = 1'b0;
    rate_sel = 6'h03;
    freq_set = 24'h001000;
    do_reset(1'b0);
    lock_up(24'h001000);
    present = 1'b0;
    step(2);
    chm(`PMS_MODE_FREE);
    chk({23'h0, ready}, 24'h0);
    do_reset(1'b1);
    fastlock_en = 1'b0;
    lock_up(24'h002000);
    present = 1'b0;
    step(2);
    chm(`PMS_MODE_FREEZE);
    step(5);
    chk(freq_cmd, 24'h002000);
    fastlock_en = 1'b1;
    lock_up(24'h001000);
    // a late step of the input lands only in the newest sample, which the delay drops
    step(55);
    freq_set = 24'h001100;
    step(5);
    chk({23'h0, ready}, 24'h1);
    present = 1'b0;
    step(2);
    chm(`PMS_MODE_HOLD);
    chk({22'h0, freq_src}, {22'h0, `PMS_SRC_HELD});
    chk(freq_cmd, 24'h001000);
    // 60 apart at rate 6 is ten ticks of four cycles
    freq_set = 24'h00103c;
    present = 1'b1;
    step(2);
    chm(`PMS_MODE_EXIT);
    cnt = 0;
    while (mode === `PMS_MODE_EXIT && cnt < 500) begin
      last = freq_cmd;
      step(1);
      cnt++;
    end
    chk(last, 24'h00103c);
    chk({23'h0, cnt >= 36 && cnt <= 100}, 24'h1);
    chm(`PMS_MODE_ACQ);
    acq_done = 1'b1;
    step(1);
    acq_done = 1'b0;
    present = 1'b0;
    step(2);
    chm(`PMS_MODE_HOLD);
    bypass = 1'b1;
    present = 1'b1;
    step(2);
    chm(`PMS_MODE_ACQ);
    chk({22'h0, bw_sel}, {22'h0, `PMS_BW_HOLD_EXIT});
    close_out();
  end
endmodule
`default_nettype wire

// ===== verilog/pms_history.v
`timescale 1ns/10ps
`default_nettype none
`include "pms_regs.vh"

module pms_history #(
  parameter FW = 24,
  parameter DEPTH = `PMS_HIST_DEPTH,
  parameter AW = `PMS_HIST_AW
) (
  input wire clk, // system clock
  input wire rst_n, // synchronised reset, active low
  input wire sample, // one-cycle sample strobe
  input wire record, // locked to a valid input
  input wire [FW-1:0] freq_in, // measured input frequency
  input wire [2:0] len_log2, // window length, log2 of samples
  input wire [AW-1:0] delay, // samples skipped at the newest end
  output reg ready, // history valid
  output reg [FW-1:0] avg // averaged holdover frequency
);

  localparam [AW-1:0] ONE = 1;
  localparam [AW:0] FULL = DEPTH;

  reg [FW-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW:0] fill;
  reg busy;
  reg [AW:0] idx;
  reg [FW+AW:0] acc;
  wire [AW:0] len = {{AW{1'b0}}, 1'b1} << len_log2;
  wire [AW:0] need = len + {1'b0, delay};
  wire [AW-1:0] rd = wr_ptr - ONE - delay - idx[AW-1:0];
  wire [FW+AW:0] acc_next = acc + {{(AW+1){1'b0}}, mem[rd]};
  wire [FW+AW:0] acc_mean = acc_next >> len_log2;

  // ==========================================================
  // sample store; paused whenever the input is absent
  always @(posedge clk) begin
    if (sample && record) begin
      mem[wr_ptr] <= freq_in;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= {AW{1'b0}};
      fill <= {(AW+1){1'b0}};
      busy <= 1'b0;
      idx <= {(AW+1){1'b0}};
      acc <= {(FW+AW+1){1'b0}};
      ready <= 1'b0;
      avg <= {FW{1'b0}};
    end else begin
      ready <= (fill >= need);
      if (sample && record) begin
        wr_ptr <= wr_ptr + ONE;
        if (fill != FULL) begin
          fill <= fill + {{AW{1'b0}}, 1'b1};
        end
        busy <= 1'b1;
        idx <= {(AW+1){1'b0}};
        acc <= {(FW+AW+1){1'b0}};
      end else if (busy) begin
        // one stored sample per cycle; an average of old and new input
        // frequencies falls out naturally until the window refills
        acc <= acc_next;
        idx <= idx + {{AW{1'b0}}, 1'b1};
        if (idx == len - {{AW{1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          avg <= acc_mean[FW-1:0];
        end
      end
    end
  end

endmodule
`default_nettype wire

// ===== verilog/pms_ramp.v
`timescale 1ns/10ps
`default_nettype none
`include "pms_regs.vh"

module pms_ramp #(
  parameter FW = 24
) (
  input wire clk, // system clock
  input wire rst_n, // synchronised reset, active low
  input wire start, // one-cycle start of a ramped exit
  input wire tick, // one-cycle ramp step strobe
  input wire [FW-1:0] from_freq, // holdover frequency
  input wire [FW-1:0] to_freq, // desired new frequency
  input wire [5:0] rate_sel, // ramp rate setting
  output wire active, // ramp running
  output reg done, // one-cycle end of ramp
  output reg [FW-1:0] freq // ramped frequency
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_CALC = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;

  reg [2:0] state;
  reg up;
  reg [FW-1:0] mag;
  reg [FW-1:0] rate;
  reg [FW-1:0] dur;
  reg [FW-1:0] target;

  // two mantissas per octave gives close to forty distinct rates
  function [FW-1:0] rate_of;
    input [5:0] sel;
    reg [31:0] r;
    begin
      r = {30'h0, 1'b1, sel[0]} << sel[5:1];
      if (sel > `PMS_RATE_SEL_MAX || r > `PMS_RATE_MAX_X10) begin
        r = `PMS_RATE_MAX_X10;
      end
      if (r < `PMS_RATE_MIN_X10) begin
        r = `PMS_RATE_MIN_X10;
      end
      rate_of = r[FW-1:0];
    end
  endfunction

  assign active = (state != ST_IDLE);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      up <= 1'b0;
      mag <= {FW{1'b0}};
      rate <= {FW{1'b0}};
      dur <= {FW{1'b0}};
      target <= {FW{1'b0}};
      freq <= {FW{1'b0}};
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start) begin
            up <= (to_freq >= from_freq);
            mag <= (to_freq >= from_freq) ? to_freq - from_freq : from_freq - to_freq;
            rate <= rate_of(rate_sel);
            dur <= {FW{1'b0}};
            target <= to_freq;
            freq <= from_freq;
            state <= ST_CALC;
          end
        end
        ST_CALC: begin
          // duration by repeated subtraction: slow but small, and the
          // loop is idle in holdover anyway
          if (mag >= rate) begin
            mag <= mag - rate;
            dur <= dur + {{(FW-1){1'b0}}, 1'b1};
          end else begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (tick) begin
            if (dur == {FW{1'b0}}) begin
              freq <= target;
              done <= 1'b1;
              state <= ST_IDLE;
            end else begin
              freq <= up ? freq + rate : freq - rate;
              dur <= dur - {{(FW-1){1'b0}}, 1'b1};
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== verilog/pms_regs.vh
`ifndef PMS_REGS_VH
`define PMS_REGS_VH

// ==========================================================
// clock and timing
`define PMS_CLK_HZ 50000000
`define PMS_CLK_NS 20
`define PMS_RAMP_TICK_NS 1000000
`define PMS_TICK_CYCLES (`PMS_RAMP_TICK_NS / `PMS_CLK_NS)
`define PMS_HIST_SPAN_S 120
`define PMS_HIST_DEPTH 32
`define PMS_HIST_AW 5
`define PMS_SAMPLE_CYCLES (`PMS_HIST_SPAN_S * (`PMS_CLK_HZ / `PMS_HIST_DEPTH))

// ==========================================================
// ramp rate limits, in units of 0.1 ppm/s
`define PMS_RATE_MIN_X10 32'h0000_0002
`define PMS_RATE_MAX_X10 32'h0006_1a80
`define PMS_RATE_SEL_MAX 6'h27

// ==========================================================
// encoded mode status
`define PMS_MODE_INIT 3'h0
`define PMS_MODE_FREE 3'h1
`define PMS_MODE_ACQ 3'h2
`define PMS_MODE_LOCK 3'h3
`define PMS_MODE_HOLD 3'h4
`define PMS_MODE_FREEZE 3'h5
`define PMS_MODE_EXIT 3'h6

// ==========================================================
// loop bandwidth selection
`define PMS_BW_NORMAL 2'h0
`define PMS_BW_FAST 2'h1
`define PMS_BW_HOLD_EXIT 2'h2

// ==========================================================
// frequency source for the loop filter
`define PMS_SRC_NONE 2'h0
`define PMS_SRC_REF 2'h1
`define PMS_SRC_INPUT 2'h2
`define PMS_SRC_HELD 2'h3

`endif

// ===== verilog/pms_top.v
//
// Contract
// - after init, free run from reference
// - valid input starts acquisition automatically
// - fastlock bandwidth in acquisition, then normal
// - locked mode follows selected input
// - lock lost status bit reflects lock
// - input fails, no alternative: holdover
// - record history while locked, 120 s
// - average over window, delay skips newest
// - holdover pulls to average, relock glitchless
// - ramp exit: measure, compute duration, apply
// - 37 distinct ramp rates, 0.2 to 40000 ppm/s
// - ramp rate independent of bandwidth
// - history ready after length plus delay
// - history pauses while input absent
// - average settles after one window plus delay
// - no history: freeze at last frequency
// - valid input leaves freeze, relocks
// - ramp bypass uses holdover exit bandwidth
//
`timescale 1ns/10ps
`default_nettype none
`include "pms_regs.vh"

module pms_top #(
  parameter FW = 24,
  parameter TICK_CYCLES = `PMS_TICK_CYCLES,
  parameter SAMPLE_CYCLES = `PMS_SAMPLE_CYCLES
) (
  input wire CLOCK, // 50 MHz reference-derived clock
  input wire RST_N, // asynchronous reset, active low
  input wire INIT_DONE, // power-up initialisation finished
  input wire INPUT_VALID, // a valid input is selected
  input wire [FW-1:0] MEAS_FREQ, // measured input frequency
  input wire ACQ_DONE, // lock acquisition complete
  input wire FASTLOCK_EN, // accelerated locking enable
  input wire RAMP_EXIT_BYPASS, // holdover exit without ramp
  input wire [5:0] RAMP_RATE_SEL, // ramp rate setting
  input wire [2:0] HISTORY_WINDOW_LENGTH, // log2 of window samples
  input wire [4:0] HISTORY_WINDOW_DELAY, // samples skipped
  input wire FALLBACK_FREEZE, // no-history fallback: 1 freeze, 0 free run
  output reg [2:0] MODE, // encoded operating mode
  output reg LOCK_LOST, // high while not locked
  output wire HISTORY_READY_FLAG, // holdover history valid
  output reg [1:0] BW_SEL, // loop bandwidth in use
  output reg [1:0] FREQ_SRC, // what steers the loop
  output reg [FW-1:0] FREQ_CMD // frequency measured, held or ramped
);

  localparam [6:0] ST_INIT = 7'b0000001;
  localparam [6:0] ST_FREE = 7'b0000010;
  localparam [6:0] ST_ACQ = 7'b0000100;
  localparam [6:0] ST_LOCK = 7'b0001000;
  localparam [6:0] ST_HOLD = 7'b0010000;
  localparam [6:0] ST_FREEZE = 7'b0100000;
  localparam [6:0] ST_EXIT = 7'b1000000;
  localparam [31:0] TICK_LAST = TICK_CYCLES - 1;
  localparam [31:0] SAMPLE_LAST = SAMPLE_CYCLES - 1;

  // ==========================================================
  // reset release
  reg rst_meta;
  reg rst_n;

  // assert at once but lift only on a clock edge, so no flop sees a runt release
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ==========================================================
  // timebases: ramp step tick and history sample strobe
  reg [31:0] tick_cnt;
  reg [31:0] sample_cnt;
  reg tick;
  reg sample;

  // divider step: wraps to zero after its last count
  function [31:0] step_of;
    input [31:0] cnt;
    input [31:0] last;
    begin
      step_of = (cnt == last) ? 32'h0 : cnt + 32'h1;
    end
  endfunction

  always @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 32'h0;
      sample_cnt <= 32'h0;
      tick <= 1'b0;
      sample <= 1'b0;
    end else begin
      tick <= (tick_cnt == TICK_LAST);
      sample <= (sample_cnt == SAMPLE_LAST);
      tick_cnt <= step_of(tick_cnt, TICK_LAST);
      sample_cnt <= step_of(sample_cnt, SAMPLE_LAST);
    end
  end

  // ==========================================================
  // state machine
  reg [6:0] state;
  reg [6:0] next_state;
  reg exit_bw;
  reg next_exit_bw;
  reg [FW-1:0] last_meas;
  reg [FW-1:0] frozen;
  wire [FW-1:0] hist_avg;
  wire ramp_active;
  wire ramp_done;
  wire [FW-1:0] ramp_freq;
  wire ramp_start;
  wire [6:0] lost_state;

  // history flag alone chooses holdover over the fallback path
  assign lost_state = HISTORY_READY_FLAG ? ST_HOLD :
                      (FALLBACK_FREEZE ? ST_FREEZE : ST_FREE);
  assign ramp_start = (state == ST_HOLD) && INPUT_VALID && !RAMP_EXIT_BYPASS;

  pms_history #(
    .FW(FW),
    .DEPTH(`PMS_HIST_DEPTH),
    .AW(`PMS_HIST_AW)
  ) u_history (
    .clk(CLOCK),
    .rst_n(rst_n),
    .sample(sample),
    .record(INPUT_VALID && (state == ST_LOCK)),
    .freq_in(MEAS_FREQ),
    .len_log2(HISTORY_WINDOW_LENGTH),
    .delay(HISTORY_WINDOW_DELAY),
    .ready(HISTORY_READY_FLAG),
    .avg(hist_avg)
  );

  pms_ramp #(
    .FW(FW)
  ) u_ramp (
    .clk(CLOCK),
    .rst_n(rst_n),
    .start(ramp_start),
    .tick(tick),
    .from_freq(hist_avg),
    .to_freq(MEAS_FREQ),
    .rate_sel(RAMP_RATE_SEL),
    .active(ramp_active),
    .done(ramp_done),
    .freq(ramp_freq)
  );

  always @* begin
    next_state = state;
    next_exit_bw = exit_bw;
    case (state)
      ST_INIT: begin
        if (INIT_DONE) begin
          next_state = ST_FREE;
        end
      end
      ST_FREE: begin
        if (INPUT_VALID) begin
          next_state = ST_ACQ;
          next_exit_bw = 1'b0;
        end
      end
      ST_ACQ: begin
        if (!INPUT_VALID) begin
          next_state = lost_state;
        end else if (ACQ_DONE) begin
          next_state = ST_LOCK;
          next_exit_bw = 1'b0;
        end
      end
      ST_LOCK: begin
        if (!INPUT_VALID) begin
          next_state = lost_state;
        end
      end
      ST_HOLD: begin
        if (INPUT_VALID) begin
          next_state = RAMP_EXIT_BYPASS ? ST_ACQ : ST_EXIT;
          next_exit_bw = RAMP_EXIT_BYPASS;
        end
      end
      ST_EXIT: begin
        if (!INPUT_VALID) begin
          // a lost input mid-ramp falls back to the held average; the ramp runs out unseen
          next_state = ST_HOLD;
        end else if (ramp_done) begin
          next_state = ST_ACQ;
          next_exit_bw = 1'b0;
        end
      end
      ST_FREEZE: begin
        if (INPUT_VALID) begin
          next_state = ST_ACQ;
          next_exit_bw = 1'b0;
        end
      end
      default: begin
        next_state = ST_INIT;
      end
    endcase
  end

  always @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_INIT;
      exit_bw <= 1'b0;
      last_meas <= {FW{1'b0}};
      frozen <= {FW{1'b0}};
    end else begin
      state <= next_state;
      exit_bw <= next_exit_bw;
      if (INPUT_VALID) begin
        last_meas <= MEAS_FREQ;
      end
      if (next_state == ST_FREEZE && state != ST_FREEZE) begin
        frozen <= last_meas;
      end
    end
  end

  // ==========================================================
  // status code of the one-hot state
  function [2:0] mode_of;
    input [6:0] st;
    begin
      case (st)
        ST_FREE: mode_of = `PMS_MODE_FREE;
        ST_ACQ: mode_of = `PMS_MODE_ACQ;
        ST_LOCK: mode_of = `PMS_MODE_LOCK;
        ST_HOLD: mode_of = `PMS_MODE_HOLD;
        ST_EXIT: mode_of = `PMS_MODE_EXIT;
        ST_FREEZE: mode_of = `PMS_MODE_FREEZE;
        default: mode_of = `PMS_MODE_INIT;
      endcase
    end
  endfunction

  // ==========================================================
  // registered status and loop controls
  always @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      MODE <= `PMS_MODE_INIT;
      LOCK_LOST <= 1'b1;
      BW_SEL <= `PMS_BW_NORMAL;
      FREQ_SRC <= `PMS_SRC_NONE;
      FREQ_CMD <= {FW{1'b0}};
    end else begin
      LOCK_LOST <= (next_state != ST_LOCK);
      BW_SEL <= `PMS_BW_NORMAL;
      FREQ_SRC <= `PMS_SRC_INPUT;
      FREQ_CMD <= MEAS_FREQ;
      MODE <= mode_of(next_state);
      case (next_state)
        ST_INIT: begin
          FREQ_SRC <= `PMS_SRC_NONE; // outputs stay off until init ends
        end
        ST_FREE: begin
          FREQ_SRC <= `PMS_SRC_REF;
        end
        ST_ACQ: begin
          if (next_exit_bw) begin
            BW_SEL <= `PMS_BW_HOLD_EXIT;
          end else if (FASTLOCK_EN) begin
            BW_SEL <= `PMS_BW_FAST;
          end
        end
        ST_LOCK: begin
          FREQ_CMD <= MEAS_FREQ;
        end
        ST_HOLD: begin
          FREQ_SRC <= `PMS_SRC_HELD;
          FREQ_CMD <= hist_avg;
        end
        ST_EXIT: begin
          FREQ_SRC <= `PMS_SRC_HELD;
          FREQ_CMD <= ramp_active ? ramp_freq : hist_avg;
        end
        ST_FREEZE: begin
          FREQ_SRC <= `PMS_SRC_HELD;
          // first freeze cycle shows last_meas, since frozen loads on that same edge
          FREQ_CMD <= (state == ST_FREEZE) ? frozen : last_meas;
        end
        default: begin
          FREQ_SRC <= `PMS_SRC_NONE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire
